// file: hdl/fpoll_pkg.sv
// Package of constants for the flash completion-polling host controller.
package fpoll_pkg;
    // Status word bit positions on the low data byte.
    localparam int unsigned POS_POLARITY     = 7;
    localparam int unsigned POS_TOGGLE       = 6;
    localparam int unsigned POS_TIMEOUT      = 5;
    localparam int unsigned POS_ERASE_TIMER  = 3;
    localparam int unsigned POS_SECTOR_TOG   = 2;
    localparam int unsigned POS_ABORT        = 1;
    // Flash bus geometry.
    localparam int unsigned DATA_W           = 16;
    localparam int unsigned ADDR_W           = 26;
    // Command words written to the flash.
    localparam logic [15:0] CMD_RESET        = 16'h00F0;
    localparam logic [15:0] CMD_ABORT_RESET  = 16'h00F0;
    localparam logic [15:0] CMD_SR_CLEAR     = 16'h0071;
    localparam logic [15:0] CMD_SR_READ      = 16'h0070;
    // Unlock cycles of the abort-reset sequence.
    localparam logic [ADDR_W-1:0] UNLOCK_A1  = 26'h000_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2  = 26'h000_02AA;
    localparam logic [15:0] UNLOCK_D1        = 16'h00AA;
    localparam logic [15:0] UNLOCK_D2        = 16'h0055;
    // Bus cycle timing.
    localparam int unsigned CLK_PERIOD_PS    = 25000;
    localparam int unsigned BUS_CYCLE_NS     = 100;
    localparam int unsigned BUS_CYCLES       =
        (BUS_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Busy time that may follow a reset after a timeout.
    localparam int unsigned RESET_BUSY_US    = 2;
    localparam int unsigned RESET_BUSY_CYC   =
        (RESET_BUSY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Result codes.
    localparam logic [1:0] RES_DONE          = 2'h0;
    localparam logic [1:0] RES_TIMEOUT       = 2'h1;
    localparam logic [1:0] RES_ABORT         = 2'h2;
    localparam logic [1:0] RES_ERROR         = 2'h3;
endpackage : fpoll_pkg

// file: hdl/fpoll_buscycle.sv
// One asynchronous flash bus cycle, read or write, with fixed strobe width.
`timescale 1ns/1ps
`default_nettype none
module fpoll_buscycle #(
    parameter int unsigned CYCLES = fpoll_pkg::BUS_CYCLES
) (
    // Clock and reset
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    // Request
    input  wire logic                          i_start,
    input  wire logic                          i_write,
    input  wire logic [fpoll_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [fpoll_pkg::DATA_W-1:0]  i_wdata,
    // Answer
    output logic                               o_done,
    output logic [fpoll_pkg::DATA_W-1:0]       o_rdata,
    // Flash pins
    output logic [fpoll_pkg::ADDR_W-1:0]       o_addr,
    output logic                               o_ce_n,
    output logic                               o_oe_n,
    output logic                               o_we_n,
    output logic [fpoll_pkg::DATA_W-1:0]       o_dq,
    output logic                               o_dq_oe,
    input  wire logic [fpoll_pkg::DATA_W-1:0]  i_dq
);
    initial begin
        if (CYCLES < 1 || CYCLES > 255) begin
            $error("fpoll_buscycle: CYCLES out of range");
        end
    end

    logic [7:0] cnt;
    logic       busy;
    wire        last = busy && (cnt == 8'(CYCLES - 1));

    // Every read is a full cycle with OE released afterwards, so the device
    // sees a distinct read cycle and can advance its toggle bits.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            busy    <= 1'b0;
            cnt     <= 8'h00;
            o_done  <= 1'b0;
            o_rdata <= 16'h0000;
            o_addr  <= 26'h000_0000;
            o_ce_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            o_we_n  <= 1'b1;
            o_dq    <= 16'h0000;
            o_dq_oe <= 1'b0;
        end else begin
            o_done <= last;
            if (i_start && !busy) begin
                busy    <= 1'b1;
                cnt     <= 8'h00;
                o_addr  <= i_addr;
                o_ce_n  <= 1'b0;
                o_oe_n  <= i_write;
                o_we_n  <= !i_write;
                o_dq    <= i_wdata;
                o_dq_oe <= i_write;
            end else if (last) begin
                busy    <= 1'b0;
                o_rdata <= i_dq;
                o_ce_n  <= 1'b1;
                o_oe_n  <= 1'b1;
                o_we_n  <= 1'b1;
                o_dq_oe <= 1'b0;
            end else if (busy) begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule : fpoll_buscycle
`default_nettype wire

// file: hdl/fpoll_ctrl.sv
// Host controller that polls a flash operation to completion and clears errors.
//
// Operation
// - Read status twice in a row and compare the toggle bit.
// - Toggling with timeout high: recheck; still toggling means fail, write reset (the code writes 0x71 clear when status bit 5 or 4 is set).
// - Polling abandoned and resumed restarts with the double read.
// - After timeout write reset; allow up to 2 us of residual busy. The code writes the 0x71 status clear instead when status bit 5 or 4 is set.
// - On abort flag write the abort-reset sequence, clearing failure bits.
// - Non-suspended sectors give array data; program-suspended data is invalid.
// - Host reads status at an address in the targeted word or sector.
// - In error only status read, reset and clear; host must clear it.
`timescale 1ns/1ps
`default_nettype none
module fpoll_ctrl #(
    parameter int unsigned RESET_BUSY_CYC = fpoll_pkg::RESET_BUSY_CYC
) (
    // Clock and reset
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    // User command port
    input  wire logic                          i_start,
    input  wire logic                          i_abandon,
    input  wire logic [fpoll_pkg::ADDR_W-1:0]  i_target_addr,
    output logic                               o_busy,
    output logic                               o_done,
    output logic [1:0]                         o_result,
    output logic [7:0]                         o_status_reg,
    output logic [fpoll_pkg::DATA_W-1:0]       o_array_data,
    // Flash pins
    output logic [fpoll_pkg::ADDR_W-1:0]       o_flash_addr,
    output logic                               o_flash_ce_n,
    output logic                               o_flash_oe_n,
    output logic                               o_flash_we_n,
    output logic [fpoll_pkg::DATA_W-1:0]       o_flash_dq,
    output logic                               o_flash_dq_oe,
    input  wire logic [fpoll_pkg::DATA_W-1:0]  i_flash_dq,
    input  wire logic                          i_ready_busy_pin
);
    initial begin
        if (RESET_BUSY_CYC < 1 || RESET_BUSY_CYC >= (1 << 20)) begin
            $error("fpoll_ctrl: RESET_BUSY_CYC out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_READ1   = 4'b0001,
        ST_READ2   = 4'b0011,
        ST_RECHK   = 4'b0010,
        ST_ARRAY   = 4'b0110,
        ST_SR_RD   = 4'b0111,
        ST_SR_GET  = 4'b0101,
        ST_CLEAR   = 4'b0100,
        ST_UNLK1   = 4'b1100,
        ST_UNLK2   = 4'b1101,
        ST_SETTLE  = 4'b1111,
        ST_FINISH  = 4'b1110
    } fpoll_state_e;

    fpoll_state_e state;
    fpoll_state_e next_state;

    logic [fpoll_pkg::ADDR_W-1:0] addr;
    logic                         first_toggle;
    logic [1:0]                   result;
    logic [19:0]                  settle_cnt;
    logic                         issued;

    // Bus cycle engine.
    logic                         bc_start;
    logic                         bc_write;
    logic [fpoll_pkg::ADDR_W-1:0] bc_addr;
    logic [fpoll_pkg::DATA_W-1:0] bc_wdata;
    logic                         bc_done;
    logic [fpoll_pkg::DATA_W-1:0] bc_rdata;

    fpoll_buscycle #(.CYCLES(fpoll_pkg::BUS_CYCLES)) u_cycle (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_start (bc_start),
        .i_write (bc_write),
        .i_addr  (bc_addr),
        .i_wdata (bc_wdata),
        .o_done  (bc_done),
        .o_rdata (bc_rdata),
        .o_addr  (o_flash_addr),
        .o_ce_n  (o_flash_ce_n),
        .o_oe_n  (o_flash_oe_n),
        .o_we_n  (o_flash_we_n),
        .o_dq    (o_flash_dq),
        .o_dq_oe (o_flash_dq_oe),
        .i_dq    (i_flash_dq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Upper data byte is undefined while status is overlaid, so only the
    // low byte is examined.
    wire tog_now   = bc_rdata[fpoll_pkg::POS_TOGGLE];
    wire timed_out = bc_rdata[fpoll_pkg::POS_TIMEOUT];
    wire aborted   = bc_rdata[fpoll_pkg::POS_ABORT];
    wire toggling  = tog_now != first_toggle;
    wire is_write  = (state == ST_CLEAR) || (state == ST_UNLK1) || (state == ST_UNLK2);
    wire is_sr_rd  = state == ST_SR_RD;
    wire sr_err    = bc_rdata[5] || bc_rdata[4];

    function automatic logic [fpoll_pkg::DATA_W-1:0] clear_cmd(input logic [1:0] res,
                                                             input logic [1:0] step);
        if (res == fpoll_pkg::RES_ABORT) begin
            clear_cmd = (step == 2'd0) ? fpoll_pkg::UNLOCK_D1 :
                        (step == 2'd1) ? fpoll_pkg::UNLOCK_D2 : fpoll_pkg::CMD_ABORT_RESET;
        end else if (res == fpoll_pkg::RES_ERROR) begin
            clear_cmd = fpoll_pkg::CMD_SR_CLEAR;
        end else begin
            clear_cmd = fpoll_pkg::CMD_RESET;
        end
    endfunction : clear_cmd

    assign bc_write = is_write || is_sr_rd;
    assign bc_addr  = (state == ST_UNLK1) ? fpoll_pkg::UNLOCK_A1 :
                      (state == ST_UNLK2) ? fpoll_pkg::UNLOCK_A2 :
                      is_sr_rd            ? fpoll_pkg::UNLOCK_A1 : addr;
    assign bc_wdata = is_sr_rd            ? fpoll_pkg::CMD_SR_READ :
                      (state == ST_UNLK1) ? clear_cmd(result, 2'd0) :
                      (state == ST_UNLK2) ? clear_cmd(result, 2'd1) :
                                            clear_cmd(result, 2'd2);
    assign bc_start = (state != ST_IDLE) && (state != ST_SETTLE) && (state != ST_FINISH)
                      && !issued;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_state = ST_READ1;
                end
            end
            ST_READ1: begin
                if (bc_done) begin
                    next_state = ST_READ2;
                end
            end
            ST_READ2: begin
                if (bc_done && i_abandon) begin
                    next_state = ST_IDLE;
                end else if (bc_done && !toggling) begin
                    next_state = ST_ARRAY;
                // recheck on flags
                // The second read may already be array data whose bits only look like
                // flags, so a flag is trusted only after a further toggling read.
                end else if (bc_done && (timed_out || aborted)) begin
                    next_state = ST_RECHK;
                end else if (bc_done) begin
                    next_state = ST_READ2;
                end
            end
            ST_RECHK: begin
                if (bc_done && !toggling) begin
                    next_state = ST_ARRAY;
                end else if (bc_done && aborted) begin
                    next_state = ST_UNLK1;
                end else if (bc_done) begin
                    next_state = ST_SR_RD;
                end
            end
            ST_SR_RD: begin
                if (bc_done) begin
                    next_state = ST_SR_GET;
                end
            end
            ST_SR_GET: begin
                if (bc_done) begin
                    next_state = ST_CLEAR;
                end
            end
            ST_UNLK1: begin
                if (bc_done) begin
                    next_state = ST_UNLK2;
                end
            end
            ST_UNLK2: begin
                if (bc_done) begin
                    next_state = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                if (bc_done) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (i_ready_busy_pin || settle_cnt == 20'(RESET_BUSY_CYC - 1)) begin
                    next_state = ST_FINISH;
                end
            end
            ST_ARRAY: begin
                if (bc_done) begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state        <= ST_IDLE;
            addr         <= 26'h000_0000;
            first_toggle <= 1'b0;
            result       <= fpoll_pkg::RES_DONE;
            settle_cnt   <= 20'h0_0000;
            issued       <= 1'b0;
            o_busy       <= 1'b0;
            o_done       <= 1'b0;
            o_result     <= fpoll_pkg::RES_DONE;
            o_status_reg <= 8'h00;
            o_array_data <= 16'h0000;
        end else begin
            state      <= next_state;
            issued     <= (next_state == state) && (issued || bc_start) && !bc_done;
            settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 20'h0_0001 : 20'h0_0000;
            o_busy     <= next_state != ST_IDLE;
            o_done     <= state == ST_FINISH;
            if (state == ST_IDLE && i_start) begin
                addr   <= i_target_addr;
                result <= fpoll_pkg::RES_DONE;
            end
            if (bc_done && (state == ST_READ1 || state == ST_READ2 || state == ST_RECHK)) begin
                first_toggle <= tog_now;
            end
            if (state == ST_RECHK && bc_done && toggling && aborted) begin
                result <= fpoll_pkg::RES_ABORT;
            end
            if (state == ST_SR_GET && bc_done) begin
                o_status_reg <= bc_rdata[7:0];
                result       <= sr_err ? fpoll_pkg::RES_ERROR : fpoll_pkg::RES_TIMEOUT;
            end
            if (state == ST_ARRAY && bc_done) begin
                o_array_data <= bc_rdata;
            end
            if (state == ST_FINISH) begin
                o_result <= result;
            end
        end
    end
endmodule : fpoll_ctrl
`default_nettype wire

// file: sim/fpoll_chk.sv
// Concurrent checks on the polling controller's handshake and flash strobes.
`timescale 1ns/1ps
`default_nettype none
module fpoll_chk (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // Observed ports
    input  wire logic i_start,
    input  wire logic o_busy,
    input  wire logic o_done,
    input  wire logic o_flash_ce_n,
    input  wire logic o_flash_oe_n,
    input  wire logic o_flash_we_n,
    input  wire logic o_flash_dq_oe
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    sequence s_read_strobe;
        (!o_flash_ce_n && !o_flash_oe_n)[*4];
    endsequence
    sequence s_done_then_idle;
        o_done ##1 (!o_done && !o_busy);
    endsequence
    a_read_width: assert property ($fell(o_flash_oe_n) |-> s_read_strobe)
        else $error("read strobe shorter than four cycles");
    a_read_released: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && o_flash_we_n)
        else $error("data driven during a read");
    a_write_drives: assert property (!o_flash_we_n |-> o_flash_dq_oe && !o_flash_ce_n)
        else $error("write strobe without driven data");
    a_done_ends_poll: assert property (o_done |-> s_done_then_idle)
        else $error("done not a single pulse ending the poll");
    a_done_after_busy: assert property (o_done |-> $past(o_busy))
        else $error("done without a running poll");
    a_busy_from_start: assert property ($rose(o_busy) |-> $past(i_start))
        else $error("poll began without a start");
    a_bus_only_busy: assert property (!o_flash_ce_n |-> o_busy)
        else $error("flash selected outside a poll");
    a_strobes_apart: assert property (!(!o_flash_oe_n && !o_flash_we_n))
        else $error("read and write strobes together");
endmodule : fpoll_chk
bind fpoll_ctrl fpoll_chk fpoll_chk_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .o_busy(o_busy), .o_done(o_done),
    .o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n),
    .o_flash_dq_oe(o_flash_dq_oe));
`default_nettype wire

// file: sim/fpoll_flash_model.sv
// Behavioural flash device answering status polls, error clears and array reads.
`timescale 1ns/1ps
`default_nettype none
module fpoll_flash_model (
    // Clock used to sample write data and read data and to count down the reset hold
    input  wire logic                         i_mclk,
    // Flash pins, and the target address that status reads are checked against
    input  wire logic [fpoll_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                         i_ce_n,
    input  wire logic                         i_oe_n,
    input  wire logic                         i_we_n,
    input  wire logic [fpoll_pkg::DATA_W-1:0] i_dq,
    input  wire logic [fpoll_pkg::ADDR_W-1:0] i_tgt,
    output logic      [fpoll_pkg::DATA_W-1:0] o_dq,
    output logic                              o_ready_busy_pin
);
    // Modes: 0 array, 1 buffer busy, 2 timeout, 3 abort, 4 failed operation.
    int          mode = 0;
    int          left = 0;
    int          unlock = 0;
    int          hold = 0;
    int          bad_cmd = 0;
    int          bad_addr = 0;
    logic        first_toggle_bit = 1'b0;
    logic        we_seen = 1'b0;
    logic        status_pending = 1'b0;
    logic        abort_seq_ok = 1'b0;
    logic [7:0]  op_status = 8'h00;
    logic [15:0] arr = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] clr_cmd = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic [fpoll_pkg::ADDR_W-1:0] wa = '0;
    wire  [7:0]  status;
    assign status = {~arr[7], first_toggle_bit, (mode == 2 || mode == 4), last[4], (mode == 4),
                     (mode == 4 && first_toggle_bit), (mode == 3 || mode == 4), last[0]};
    // busy in every mode but 0 (array) and briefly after reset.
    assign o_ready_busy_pin = (mode == 0) && (hold == 0);
    // A released bus shows the inverse of the last value so stale data never matches.
    assign o_dq = (i_ce_n || i_oe_n) ? ~last : status_pending ? {8'h00, op_status} :
                  (mode == 0) ? arr : {~last[15:8], status};
    always @(negedge i_mclk) begin
        if (!i_we_n) begin
            wa <= i_addr;
            wd <= i_dq;
            we_seen <= 1'b1;
        end
        if (!i_ce_n && !i_oe_n) begin
            last <= o_dq;
            if ((mode == 1 || mode == 3) && !status_pending && i_addr !== i_tgt)
                bad_addr <= bad_addr + 1;
        end
        if (hold > 0)
            hold <= hold - 1;
    end
    // toggle on every read except a status-register read until done.
    always @(posedge i_oe_n) begin
        if (status_pending)
            status_pending = 1'b0;
        else if (mode != 0) begin
            first_toggle_bit = ~first_toggle_bit;
            left = left - 1;
            if (mode == 1 && left <= 0)
                mode = 0;
        end
    end
    always @(posedge i_we_n) begin
        if (mode == 2 || mode == 4) begin
            if (wd == fpoll_pkg::CMD_SR_READ)
                status_pending = 1'b1;
            else if (wd == fpoll_pkg::CMD_RESET || wd == fpoll_pkg::CMD_SR_CLEAR) begin
                clr_cmd = wd;
                mode = 0;
                hold = 2;
            end
        end else if (mode == 3) begin
            if (wa == fpoll_pkg::UNLOCK_A1 && wd == fpoll_pkg::UNLOCK_D1)
                unlock = 1;
            else if (unlock == 1 && wa == fpoll_pkg::UNLOCK_A2 && wd == fpoll_pkg::UNLOCK_D2)
                unlock = 2;
            else if (unlock == 2 && wd == fpoll_pkg::CMD_ABORT_RESET) begin
                abort_seq_ok = 1'b1;
                mode = 0;
            end else
                unlock = 0;
        end else if (we_seen)
            bad_cmd = bad_cmd + 1;
    end
endmodule : fpoll_flash_model
`default_nettype wire

// file: sim/fpoll_ctrl_test.sv
// Self-checking bench for the flash polling controller against a device model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module fpoll_ctrl_test;
    logic                         i_mclk = 1'b0;
    logic                         i_rst = 1'b1;
    logic                         i_start = 1'b0;
    logic                         i_abandon = 1'b0;
    logic [fpoll_pkg::ADDR_W-1:0] i_target_addr = '0;
    logic [fpoll_pkg::ADDR_W-1:0] f_addr;
    logic [fpoll_pkg::DATA_W-1:0] f_dq, m_dq, rd_data;
    logic                         o_busy, o_done, ce_n, oe_n, we_n, dq_oe, rb, seen;
    logic [1:0]                   o_result;
    logic [7:0]                   o_status_reg;
    logic [31:0]                  seed = 32'h0000_001D;
    logic [31:0]                  r;
    int                           n_mismatch = 0;
    int                           cmp_count = 0;
    wire  [fpoll_pkg::DATA_W-1:0] dq_wire = dq_oe ? f_dq : m_dq;
    fpoll_ctrl #(.RESET_BUSY_CYC(4)) fpoll_ctrl_i (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .i_abandon(i_abandon),
        .i_target_addr(i_target_addr), .o_busy(o_busy), .o_done(o_done),
        .o_result(o_result), .o_status_reg(o_status_reg), .o_array_data(rd_data),
        .o_flash_addr(f_addr), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
        .o_flash_dq(f_dq), .o_flash_dq_oe(dq_oe), .i_flash_dq(dq_wire), .i_ready_busy_pin(rb));
    fpoll_flash_model fpoll_flash_model_i (
        .i_mclk(i_mclk), .i_addr(f_addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_dq(dq_wire), .i_tgt(i_target_addr), .o_dq(m_dq), .o_ready_busy_pin(rb));
    always #12.5 i_mclk = ~i_mclk;
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    function automatic logic [1:0] expect_result(input int m, input logic [7:0] st);
        if (m >= 3)
            return fpoll_pkg::RES_ABORT;
        if (m == 2)
            return (st[5] || st[4]) ? fpoll_pkg::RES_ERROR : fpoll_pkg::RES_TIMEOUT;
        return fpoll_pkg::RES_DONE;
    endfunction : expect_result
    function automatic logic [15:0] expect_clear(input int m, input logic [7:0] st);
        if (m == 2 && (st[5] || st[4]))
            return fpoll_pkg::CMD_SR_CLEAR;
        return fpoll_pkg::CMD_RESET;
    endfunction : expect_clear
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic start_poll(input int m, input int l);
        r = xorshift();
        @(posedge i_mclk);
        #2;
        i_target_addr = r[25:0];
        fpoll_flash_model_i.mode = m;
        fpoll_flash_model_i.left = l;
        fpoll_flash_model_i.arr = r[31:16];
        fpoll_flash_model_i.op_status = r[7:0] | 8'h80;
        fpoll_flash_model_i.unlock = 0;
        fpoll_flash_model_i.abort_seq_ok = 1'b0;
        fpoll_flash_model_i.clr_cmd = 16'h0000;
        i_start = 1'b1;
        @(posedge i_mclk);
        #2;
        i_start = 1'b0;
        seen = 1'b0;
    endtask : start_poll
    task automatic run(input int m, input int l);
        start_poll(m, l);
        for (int k = 0; k < 3000 && !seen; k++) begin
            @(negedge i_mclk);
            seen = (o_done === 1'b1);
        end
        `CHK("done", 1'b1, seen)
        `CHK("result", expect_result(m, r[7:0] | 8'h80), o_result)
        if (m == 2 || m == 4)
            `CHK("clear command", expect_clear(m, r[7:0]), fpoll_flash_model_i.clr_cmd)
        if (m < 2)
            `CHK("array data", r[31:16], rd_data)
        if (m == 2)
            `CHK("status register", r[7:0] | 8'h80, o_status_reg)
        if (m == 3)
            `CHK("abort sequence", 1'b1, fpoll_flash_model_i.abort_seq_ok)
        `CHK("device cleared", 0, fpoll_flash_model_i.mode)
    endtask : run
    initial begin
        repeat (16) @(posedge i_mclk);
        #2;
        i_rst = 1'b0;
        run(0, 0);
        run(1, 1);
        // An abandoned poll must stop quietly and a new one starts from the double read.
        i_abandon = 1'b1;
        start_poll(1, 100000);
        for (int k = 0; k < 500 && o_busy !== 1'b0; k++) begin
            @(negedge i_mclk);
            seen = seen | (o_done === 1'b1);
        end
        `CHK("abandon done", 1'b0, seen)
        `CHK("abandon idle", 1'b0, o_busy)
        i_abandon = 1'b0;
        run(1, 3);
        for (int i = 0; i < 30; i++) begin
            r = xorshift();
            run(1 + int'(r[1:0]), 2 + int'(r[5:2]));
        end
        `CHK("stray writes", 0, fpoll_flash_model_i.bad_cmd)
        `CHK("status address", 0, fpoll_flash_model_i.bad_addr)
        tally_and_finish();
    end
    // About 34 polls of up to about 120 cycles each fit well inside this span.
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : fpoll_ctrl_test
`default_nettype wire
